// file: rtl/mcp_pkg.sv
// Package of offsets, field positions and timing for the monitor control pin logic.
package mcp_pkg;
   // ---------------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------------
   localparam logic [7:0]  CFG_IDX        = 8'h40;  // Configuration register index.
   localparam logic [7:0]  CFG2_IDX       = 8'h46;  // Second configuration register index.
   localparam logic [11:0] CFG_ADDR       = {2'h0, CFG_IDX, 2'h0};
   localparam logic [11:0] CFG2_ADDR      = {2'h0, CFG2_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADDR    = 12'h000;
   localparam logic [11:0] MASK_ADDR      = 12'h004;
   localparam logic [11:0] PINSTATE_ADDR  = 12'h008;

   // ---------------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------------
   localparam int CFG_THERMAL_ALERT_PIN_IN_BIT  = 0;  // 1: thermal pin is a fan-control input.
   localparam int CFG_IRQ_EN_BIT    = 1;
   localparam int CFG_RST_PULSE_BIT = 4;
   localparam int CFG_INTR_CLR_BIT  = 6;
   localparam int CFG2_INTR_CLR_BIT = 7;
   localparam int ST_INTRUSION      = 0;
   localparam int ST_FAN_REQ        = 1;
   localparam int ST_TEMP           = 2;
   localparam int ST_RST_DONE       = 3;
   localparam int ST_CLR_DONE       = 4;
   localparam int ST_W              = 5;
   localparam logic [7:0]      CFG_RESET    = 8'h00;
   localparam logic [ST_W-1:0] MASK_RESET   = 5'h00;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int CLK_KHZ        = 100_000;
   localparam int INTR_CLR_MS    = 20;
   localparam int RST_PULSE_MS   = 45;
   localparam int INTR_CLR_CYC   = INTR_CLR_MS * CLK_KHZ;
   localparam int RST_PULSE_CYC  = RST_PULSE_MS * CLK_KHZ;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mcp_pkg

// file: rtl/mcp_top.sv
// Control pin logic of a system hardware monitor with an AXI4-Lite register slave.
// Function
// - Three-level strap sets two low address bits.
// - Test mode turns strap pin into result output.
// - Thermal pin: temperature alert output or fan input.
// - Config bit pulses intrusion line low 20 ms.
// - Interrupt pin enabled by config bit, off after reset.
// - Test select high enters test mode, else analog.
// - Config bit drives reset pin low 45 ms.
// - External low on reset pin resets device.
// - External reset restores every register default.
// - Each status bit individually maskable from interrupt.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module mcp_top #(
   parameter int INTR_CLR_CYCLES  = mcp_pkg::INTR_CLR_CYC,
   parameter int RST_PULSE_CYCLES = mcp_pkg::RST_PULSE_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        ADDRESS_STRAP_PIN_I,
   input  wire logic        ADDRESS_STRAP_OPEN,
   output logic             ADDRESS_STRAP_PIN_O,
   output logic             ADDRESS_STRAP_PIN_OE,
   input  wire logic        TEST_CHAIN_RESULT,
   output logic [1:0]       SLAVE_ADDR_LSB,
   input  wire logic        TEST_SELECT_PIN,
   output logic             TEST_MODE,
   output logic             ANALOG_OUT_EN,
   input  wire logic        THERMAL_ALERT_PIN_I,
   output logic             THERMAL_ALERT_PIN_O,
   output logic             THERMAL_ALERT_PIN_OE,
   output logic             FAN_FULL_SPEED,
   input  wire logic        TEMP_EVENT,
   input  wire logic        INTRUSION_LATCH_LINE_I,
   output logic             INTRUSION_LATCH_LINE_O,
   output logic             INTRUSION_LATCH_LINE_OE,
   input  wire logic        RESET_PIN_I,
   output logic             RESET_PIN_O,
   output logic             RESET_PIN_OE,
   output logic             INT_PIN_O,
   output logic             INT_PIN_OE,
   output logic             IRQ
);
   import mcp_pkg::*;

   // ---------------------------------------------------------------------
   // Reset combining
   // ---------------------------------------------------------------------
   logic                rst_oe_reg;
   logic                clr_oe_reg;
   logic [31:0]         rst_cnt_reg;
   logic [31:0]         clr_cnt_reg;
   logic                strap_done_reg;
   logic [7:0]          cfg_reg;
   logic [7:0]          cfg2_reg;
   logic [ST_W-1:0]     status_reg;
   logic [ST_W-1:0]     mask_reg;
   logic [1:0]          addr_lsb_reg;

   // A low pin is a reset only while we are not driving it ourselves.
   wire ext_rst = !RESET_PIN_I && !rst_oe_reg;
   wire srst    = RST || ext_rst;

   // ---------------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------------
   logic                aw_held_reg;
   logic                w_held_reg;
   logic [11:0]         awaddr_reg;
   logic [31:0]         wdata_reg;
   logic [3:0]          wstrb_reg;
   logic                bvalid_reg;
   logic [1:0]          bresp_reg;

   // Address and data are latched independently; the write lands when both are held.
   assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
   wire   wr_go         = aw_held_reg && w_held_reg;
   wire   wr_cfg        = wr_go && awaddr_reg == CFG_ADDR && wstrb_reg[0];
   wire   wr_cfg2       = wr_go && awaddr_reg == CFG2_ADDR && wstrb_reg[0];
   wire   wr_stat       = wr_go && awaddr_reg == STATUS_ADDR && wstrb_reg[0];
   wire   wr_mask       = wr_go && awaddr_reg == MASK_ADDR && wstrb_reg[0];
   wire   wr_known      = awaddr_reg == CFG_ADDR || awaddr_reg == CFG2_ADDR ||
                          awaddr_reg == STATUS_ADDR || awaddr_reg == MASK_ADDR;

   // Write channel handshake and response.
   always_ff @(posedge CLK) begin
      if (srst) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         awaddr_reg  <= 12'h000;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= S_AXI_WDATA;
            wstrb_reg  <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP  = bresp_reg;

   // ---------------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------------
   logic                rvalid_reg;
   logic [31:0]         rdata_reg;
   logic [1:0]          rresp_reg;
   logic [31:0]         rd_word;
   logic                rd_known;

   assign S_AXI_ARREADY = !rvalid_reg;

   // Read multiplexer; unmapped addresses answer zero with an error.
   always_comb begin
      rd_word  = 32'h0000_0000;
      rd_known = 1'b1;
      case (S_AXI_ARADDR)
         CFG_ADDR:      rd_word = {24'h0, cfg_reg};
         CFG2_ADDR:     rd_word = {24'h0, cfg2_reg};
         STATUS_ADDR:   rd_word = {27'h0, status_reg};
         MASK_ADDR:     rd_word = {27'h0, mask_reg};
         PINSTATE_ADDR: rd_word = {24'h0, RESET_PIN_OE, INTRUSION_LATCH_LINE_OE,
                                   INTRUSION_LATCH_LINE_I, THERMAL_ALERT_PIN_I,
                                   TEST_MODE, IRQ, addr_lsb_reg};
         default:       rd_known = 1'b0;
      endcase
   end

   // Read answer register, one cycle after the address is taken.
   always_ff @(posedge CLK) begin
      if (srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA  = rdata_reg;
   assign S_AXI_RRESP  = rresp_reg;

   // ---------------------------------------------------------------------
   // Configuration, pulse requests and timers
   // ---------------------------------------------------------------------
   wire rst_req   = cfg_reg[CFG_RST_PULSE_BIT];
   wire clr_req   = cfg_reg[CFG_INTR_CLR_BIT] || cfg2_reg[CFG2_INTR_CLR_BIT];
   wire rst_end   = rst_oe_reg && rst_cnt_reg == 32'(RST_PULSE_CYCLES - 1);
   wire clr_end   = clr_oe_reg && clr_cnt_reg == 32'(INTR_CLR_CYCLES - 1);

   // Configuration registers; request bits drop when their pulse ends.
   always_ff @(posedge CLK) begin
      if (srst) begin
         cfg_reg  <= CFG_RESET;
         cfg2_reg <= CFG_RESET;
      end else begin
         if (wr_cfg) cfg_reg <= wdata_reg[7:0];
         else if (rst_end) cfg_reg[CFG_RST_PULSE_BIT] <= 1'b0;
         if (!wr_cfg && clr_end) cfg_reg[CFG_INTR_CLR_BIT] <= 1'b0;
         if (wr_cfg2) cfg2_reg <= wdata_reg[7:0];
         else if (clr_end) cfg2_reg[CFG2_INTR_CLR_BIT] <= 1'b0;
      end
   end

   // Reset pin pulse timer: low for the full count, then released.
   always_ff @(posedge CLK) begin
      if (RST) begin
         rst_oe_reg  <= 1'b0;
         rst_cnt_reg <= 32'h0000_0000;
      end else if (rst_oe_reg) begin
         rst_oe_reg  <= !rst_end;
         rst_cnt_reg <= rst_end ? 32'h0000_0000 : rst_cnt_reg + 32'h1;
      end else if (rst_req && !ext_rst) begin
         rst_oe_reg <= 1'b1;
      end
   end

   // Intrusion latch clear timer.
   always_ff @(posedge CLK) begin
      if (srst) begin
         clr_oe_reg  <= 1'b0;
         clr_cnt_reg <= 32'h0000_0000;
      end else if (clr_oe_reg) begin
         clr_oe_reg  <= !clr_end;
         clr_cnt_reg <= clr_end ? 32'h0000_0000 : clr_cnt_reg + 32'h1;
      end else if (clr_req) begin
         clr_oe_reg <= 1'b1;
      end
   end
   assign RESET_PIN_O            = 1'b0;
   assign RESET_PIN_OE           = rst_oe_reg;
   assign INTRUSION_LATCH_LINE_O  = 1'b0;
   assign INTRUSION_LATCH_LINE_OE = clr_oe_reg;

   // ---------------------------------------------------------------------
   // Status, mask and interrupt
   // ---------------------------------------------------------------------
   wire             thermal_alert_pin_in = cfg_reg[CFG_THERMAL_ALERT_PIN_IN_BIT];
   wire [ST_W-1:0]  ev;
   assign ev[ST_INTRUSION] = INTRUSION_LATCH_LINE_I && !clr_oe_reg;
   assign ev[ST_FAN_REQ]   = thermal_alert_pin_in && !THERMAL_ALERT_PIN_I;
   assign ev[ST_TEMP]      = TEMP_EVENT;
   assign ev[ST_RST_DONE]  = 1'b0;
   assign ev[ST_CLR_DONE]  = clr_end;
   wire [ST_W-1:0]  w1c    = wr_stat ? wdata_reg[ST_W-1:0] : '0;

   // Sticky status: a new event wins over a clear in the same cycle.
   always_ff @(posedge CLK) begin
      if (srst) begin
         status_reg <= '0;
         mask_reg   <= MASK_RESET;
      end else begin
         status_reg <= (status_reg & ~w1c) | ev;
         if (wr_mask) mask_reg <= wdata_reg[ST_W-1:0];
      end
   end
   assign IRQ        = |(status_reg & mask_reg);
   assign INT_PIN_O  = 1'b0;
   assign INT_PIN_OE = IRQ && cfg_reg[CFG_IRQ_EN_BIT];

   // ---------------------------------------------------------------------
   // Thermal pin, strap and test mode
   // ---------------------------------------------------------------------
   // Output mode reports unmasked temperature alerts only.
   assign THERMAL_ALERT_PIN_O  = 1'b0;
   assign THERMAL_ALERT_PIN_OE = !thermal_alert_pin_in && status_reg[ST_TEMP] &&
                                 mask_reg[ST_TEMP];
   assign FAN_FULL_SPEED       = ev[ST_FAN_REQ];

   wire [1:0] strap_dec = ADDRESS_STRAP_OPEN ? 2'h1 :
                          (ADDRESS_STRAP_PIN_I ? 2'h2 : 2'h0);

   // The strap is sampled once after reset release, outside test mode.
   always_ff @(posedge CLK) begin
      if (srst) begin
         strap_done_reg <= 1'b0;
         addr_lsb_reg   <= 2'h0;
      end else if (!strap_done_reg && !TEST_SELECT_PIN) begin
         strap_done_reg <= 1'b1;
         addr_lsb_reg   <= strap_dec;
      end
   end
   assign SLAVE_ADDR_LSB       = addr_lsb_reg;
   assign TEST_MODE            = TEST_SELECT_PIN;
   assign ANALOG_OUT_EN        = !TEST_SELECT_PIN;
   assign ADDRESS_STRAP_PIN_O  = TEST_CHAIN_RESULT;
   assign ADDRESS_STRAP_PIN_OE = TEST_SELECT_PIN;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   irq_pin_gate_a: assert property (@(posedge CLK) disable iff (srst)
      INT_PIN_OE |-> cfg_reg[CFG_IRQ_EN_BIT] && |(status_reg & mask_reg))
      else $error("Interrupt pin active while disabled or masked.");
   irq_after_rst_a: assert property (@(posedge CLK) $fell(srst) |-> !INT_PIN_OE)
      else $error("Interrupt pin active right after reset.");
   mask_blocks_a: assert property (@(posedge CLK) disable iff (srst)
      (mask_reg == '0) |-> !IRQ)
      else $error("Interrupt raised with all sources masked.");
   rst_len_a: assert property (@(posedge CLK) disable iff (RST)
      $fell(rst_oe_reg) |-> $past(rst_cnt_reg) == 32'(RST_PULSE_CYCLES - 1))
      else $error("Reset pin pulse ended early.");
   clr_len_a: assert property (@(posedge CLK) disable iff (srst)
      $fell(clr_oe_reg) |-> $past(clr_cnt_reg) == 32'(INTR_CLR_CYCLES - 1))
      else $error("Intrusion clear pulse ended early.");
   clr_self_a: assert property (@(posedge CLK) disable iff (srst)
      clr_end && !wr_cfg && !wr_cfg2 |=> !clr_req)
      else $error("Intrusion clear request stayed set after its pulse.");
   clr_start_a: assert property (@(posedge CLK) disable iff (srst)
      clr_req && !clr_oe_reg |=> clr_oe_reg)
      else $error("Intrusion clear pulse did not start.");
   strap_out_a: assert property (@(posedge CLK) disable iff (RST)
      TEST_SELECT_PIN |-> ADDRESS_STRAP_PIN_OE && !ANALOG_OUT_EN)
      else $error("Strap pin not driven in test mode.");
   sticky_a: assert property (@(posedge CLK) disable iff (srst)
      ev[ST_INTRUSION] |=> status_reg[ST_INTRUSION])
      else $error("Intrusion event lost.");
   thermal_alert_pin_out_a: assert property (@(posedge CLK) disable iff (srst)
      thermal_alert_pin_in |-> !THERMAL_ALERT_PIN_OE)
      else $error("Thermal pin driven while in input mode.");
   cov_rst_pulse: cover property (@(posedge CLK) $fell(rst_oe_reg));
   cov_clr_pulse: cover property (@(posedge CLK) $fell(clr_oe_reg));
   cov_irq_pin:   cover property (@(posedge CLK) $rose(INT_PIN_OE));
   cov_ext_rst:   cover property (@(posedge CLK) $rose(ext_rst));
endmodule : mcp_top

// file: verification/mcp_latch_model.sv
// Behavioural model of the external chassis intrusion latch.
`timescale 1ns/1ps
module mcp_latch_model (
   input  wire logic clk,
   input  wire logic event_in,
   input  wire logic clr_oe,
   output logic      line
);
   // The latch has no reset of its own; it powers up empty.
   logic captured_reg = 1'b0;

   // Capture an intrusion event; a low pull from the device empties the latch.
   always_ff @(posedge clk) begin
      if (clr_oe) begin
         captured_reg <= 1'b0;
      end else if (event_in) begin
         captured_reg <= 1'b1;
      end
   end

   // Open-drain pull from the device wins over the latch's high drive.
   assign line = clr_oe ? 1'b0 : captured_reg;
endmodule : mcp_latch_model

// file: verification/tb.sv
// Self-checking testbench of the monitor control pin logic.
`timescale 1ns/1ps
module tb;
   import mcp_pkg::*;
   localparam int CLR_N = 8;
   localparam int RST_N = 10;
   logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, strap_i = 1'b0, strap_open = 1'b0, chain = 1'b0;
   logic        test_sel = 1'b0, temp_ev = 1'b0, intr_ev = 1'b0, thermal_alert_pin_ext = 1'b1;
   logic        ext_rst_n = 1'b1, thermal_alert_pin_o, intr_o, rst_o, int_o;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, dat;
   logic [1:0]  bresp, rresp, resp, addr_lsb;
   logic        awready, wready, bvalid, arready, rvalid, strap_o, strap_oe, test_mode, aout_en;
   logic        thermal_alert_pin_oe, fan_full, intr_oe, rst_oe, int_oe, irq, intr_line;
   // A driven pin shows what the block puts on it, a released one its pull-up or the far side.
   wire         thermal_alert_pin_pin = thermal_alert_pin_oe ? thermal_alert_pin_o : thermal_alert_pin_ext;
   wire         rst_pin = rst_oe ? rst_o : ext_rst_n;
   int          n_errors = 0, checked = 0, clr_cnt = 0, clr_len = 0, rst_cnt = 0, rst_len = 0;
   int          n_clr = 0;

   always #5 clk = ~clk;

   mcp_top #(.INTR_CLR_CYCLES(CLR_N), .RST_PULSE_CYCLES(RST_N)) mcp_top_inst (
      .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .ADDRESS_STRAP_PIN_I(strap_i), .ADDRESS_STRAP_OPEN(strap_open),
      .ADDRESS_STRAP_PIN_O(strap_o), .ADDRESS_STRAP_PIN_OE(strap_oe),
      .TEST_CHAIN_RESULT(chain), .SLAVE_ADDR_LSB(addr_lsb), .TEST_SELECT_PIN(test_sel),
      .TEST_MODE(test_mode), .ANALOG_OUT_EN(aout_en), .THERMAL_ALERT_PIN_I(thermal_alert_pin_pin),
      .THERMAL_ALERT_PIN_O(thermal_alert_pin_o), .THERMAL_ALERT_PIN_OE(thermal_alert_pin_oe), .FAN_FULL_SPEED(fan_full),
      .TEMP_EVENT(temp_ev), .INTRUSION_LATCH_LINE_I(intr_line), .INTRUSION_LATCH_LINE_O(intr_o),
      .INTRUSION_LATCH_LINE_OE(intr_oe), .RESET_PIN_I(rst_pin), .RESET_PIN_O(rst_o),
      .RESET_PIN_OE(rst_oe), .INT_PIN_O(int_o), .INT_PIN_OE(int_oe), .IRQ(irq));

   mcp_latch_model mcp_latch_model_inst (.clk(clk), .event_in(intr_ev), .clr_oe(intr_oe),
      .line(intr_line));

   // Measures each low pulse in clock cycles, so a pulse is timed however the bench is busy.
   always @(posedge clk) begin
      clr_cnt <= intr_oe ? clr_cnt + 1 : 0;
      rst_cnt <= rst_oe ? rst_cnt + 1 : 0;
      if (!intr_oe && clr_cnt != 0) begin
         clr_len <= clr_cnt;
         n_clr <= n_clr + 1;
      end
      if (!rst_oe && rst_cnt != 0) rst_len <= rst_cnt;
   end

   // ---------------------------------------------------------------------
   // Bus cycles and comparison
   // ---------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk

   // Write one word; both channels are offered together and dropped as each is taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Read one word and keep data and response.
   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
      rd(a);
      chk(nm, exp, dat);
   endtask : rdchk

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_reset_state;
      rdchk(CFG_ADDR, 32'h0, "cfg");
      chk("int_oe", 32'h0, 32'(int_oe));
      chk("pin drive", 32'h0, {28'h0, thermal_alert_pin_o, intr_o, rst_o, int_o});
      rdchk(PINSTATE_ADDR, 32'h10, "pin state");
      rdchk(12'hffc, 32'h0, "unmapped data");
      chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
      wr(12'hffc, 32'hff);
      chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
   endtask : t_reset_state

   task automatic t_test_mode;
      test_sel <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         chain <= i[0];
         repeat (2) @(posedge clk);
         chk("strap_oe", 32'h1, 32'(strap_oe));
         chk("strap_o", 32'(i), 32'(strap_o));
         chk("mode", 32'h2, {30'h0, test_mode, aout_en});
      end
      test_sel <= 1'b0;
      repeat (2) @(posedge clk);
      chk("mode", 32'h1, {30'h0, test_mode, aout_en});
      chk("strap_oe", 32'h0, 32'(strap_oe));
   endtask : t_test_mode

   // Intrusion captured, reported, masked, then cleared by both request bits.
   task automatic t_intrusion;
      intr_ev <= 1'b1;
      @(posedge clk);
      intr_ev <= 1'b0;
      repeat (3) @(posedge clk);
      chk("line", 32'h1, 32'(intr_line));
      rdchk(STATUS_ADDR, 32'h01, "status");
      chk("irq masked", 32'h0, 32'(irq));
      wr(MASK_ADDR, 32'h11);
      chk("irq", 32'h1, 32'(irq));
      chk("int_oe off", 32'h0, 32'(int_oe));
      wr(CFG_ADDR, 32'h02);
      chk("int_oe on", 32'h1, 32'(int_oe));
      wr(CFG_ADDR, 32'h42);
      repeat (CLR_N + 5) @(posedge clk);
      chk("clear pulse", 32'(CLR_N), 32'(clr_len));
      chk("clear pulses", 32'h1, 32'(n_clr));
      chk("line", 32'h0, 32'(intr_line));
      rdchk(CFG_ADDR, 32'h02, "cfg");
      rdchk(STATUS_ADDR, 32'h11, "status");
      wr(STATUS_ADDR, 32'h11);
      rdchk(STATUS_ADDR, 32'h00, "status");
      chk("irq cleared", 32'h0, 32'(irq));
      wr(CFG2_ADDR, 32'h80);
      repeat (CLR_N + 5) @(posedge clk);
      chk("clear pulse 2", 32'(CLR_N), 32'(clr_len));
      chk("clear pulses 2", 32'h2, 32'(n_clr));
      rdchk(CFG2_ADDR, 32'h00, "cfg2");
   endtask : t_intrusion

   task automatic t_reset_pulse;
      wr(CFG_ADDR, 32'h10);
      repeat (RST_N + 5) @(posedge clk);
      chk("reset pulse", 32'(RST_N), 32'(rst_len));
      rdchk(CFG_ADDR, 32'h00, "cfg");
   endtask : t_reset_pulse

   // An outside low on the reset pin returns the registers to their defaults.
   task automatic t_ext_reset;
      wr(MASK_ADDR, 32'h1f);
      wr(CFG_ADDR, 32'h03);
      ext_rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      ext_rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rdchk(MASK_ADDR, 32'h0, "mask");
      rdchk(CFG_ADDR, 32'h0, "cfg");
   endtask : t_ext_reset

   task automatic t_thermal;
      temp_ev <= 1'b1;
      @(posedge clk);
      temp_ev <= 1'b0;
      repeat (2) @(posedge clk);
      chk("thermal_alert_pin masked", 32'h0, 32'(thermal_alert_pin_oe));
      wr(MASK_ADDR, 32'h04);
      chk("thermal_alert_pin alert", 32'h1, 32'(thermal_alert_pin_oe));
      wr(CFG_ADDR, 32'h01);
      chk("thermal_alert_pin input", 32'h0, 32'(thermal_alert_pin_oe));
      thermal_alert_pin_ext <= 1'b0;
      repeat (3) @(posedge clk);
      chk("fan full", 32'h1, 32'(fan_full));
      rdchk(STATUS_ADDR, 32'h06, "status");
      thermal_alert_pin_ext <= 1'b1;
   endtask : t_thermal

   // Each strap level is decoded after a fresh reset.
   task automatic t_strap;
      for (int i = 0; i < 3; i++) begin
         strap_i <= (i == 2);
         strap_open <= (i == 1);
         rst <= 1'b1;
         repeat (5) @(posedge clk);
         rst <= 1'b0;
         repeat (3) @(posedge clk);
         chk("addr_lsb", 32'(i), 32'(addr_lsb));
      end
   endtask : t_strap

   task automatic results;
      $display("Comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   // Main sequence after 5 cycles of reset.
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset_state();
      t_test_mode();
      t_intrusion();
      t_reset_pulse();
      t_ext_reset();
      t_thermal();
      t_strap();
      results();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial begin
      #100000;
      chk("watchdog", 32'h1, 32'h0);
      results();
   end
endmodule : tb
